// ---- rtl/spisad_pkg.sv ----
`default_nettype none
package spisad_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0] OFS_FLAGS     = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_MATCH     = 8'h14;
  localparam logic [7:0] OFS_DATA      = 8'h18;
  // Control fields
  localparam int CTRL_RXEN   = 0;
  localparam int CTRL_FRAME_FORMAT_SELECT   = 1;
  localparam int CTRL_MODE   = 2;
  localparam int CTRL_CHAR9  = 4;
  localparam int CTRL_W      = 5;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // Status, flag and interrupt fields
  localparam int STAT_OVF    = 2;
  localparam int STAT_SYNC   = 15;
  localparam int FLAG_TXE    = 0;
  localparam int FLAG_RXC    = 1;
  localparam int IRQ_RXC     = 0;
  localparam int IRQ_TXE     = 1;
  localparam int IRQ_OVF     = 2;
  localparam int IRQ_W       = 3;
  // Address register fields
  localparam int MATCH_ADDR_LO = 0;
  localparam int MATCH_MASK_LO = 16;
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;
  localparam logic [8:0]  DATA_RST  = 9'h000;
  // Domain crossing time
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_TIME_NS  = 100;
  localparam int SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_LOAD = 3'(SYNC_CYCLES);
  typedef enum logic [1:0] {
    AM_MASK  = 2'h0,
    AM_TWO   = 2'h1,
    AM_RANGE = 2'h2
  } spisad_address_match_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_DATA = 4'h4,
    ST_SKIP = 4'h8
  } spisad_state_t;
endpackage : spisad_pkg
`default_nettype wire

// ---- rtl/spisad_top.sv ----
`default_nettype none
module spisad_top (
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output var   logic [31:0] wb_dat_o,
  output var   logic        wb_ack_o,
  input  wire  logic        sck_i,
  input  wire  logic        ss_n_i,
  input  wire  logic        mosi_i,
  output var   logic        miso_o,
  output var   logic        miso_oe_n_o,
  output var   logic        irq_o
);
  import spisad_pkg::*;

  function automatic logic reg_is(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction : reg_is

  function automatic logic addr_hit(input logic [1:0] m, input logic [7:0] a,
                                    input logic [7:0] ad, input logic [7:0] mk);
    if (m == AM_MASK) begin
      return ((a ^ ad) & ~mk) == 8'h00;
    end else if (m == AM_TWO) begin
      return (a == ad) || (a == mk);
    end else if (m == AM_RANGE) begin
      return (a <= ad) && (a >= mk);
    end else begin
      return 1'b0;
    end
  endfunction : addr_hit

  // Bus side
  logic                req;
  logic                acc;
  logic                wr;
  logic                rd;
  logic [31:0]         wmask;
  logic [31:0]         wdat;
  logic [CTRL_W-1:0]   ctrl_bus;
  logic [CTRL_W-1:0]   ctrl_core;
  logic [15:0]         match_bus;
  logic [15:0]         match_core;
  logic [2:0]          sync_cnt;
  logic                sync_pending;
  logic [IRQ_W-1:0]    irq_stat;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    irq_ev;
  logic [31:0]         rdata;
  // Receive and transmit buffers
  logic [8:0]          rx_head;
  logic                rx_full;
  logic                rx_overflow_flag;
  logic [8:0]          tx_buf;
  logic                tx_full;
  logic [8:0]          tx_char;
  // Link side
  logic                sck_m;
  logic                sck_s;
  logic                sck_d;
  logic                ss_m;
  logic                ss_s;
  logic                ss_d;
  logic                mosi_m;
  logic                mosi_s;
  logic                rise;
  logic                fall;
  logic                frame_go;
  spisad_state_t       state;
  spisad_state_t       next_state;
  logic [3:0]          bit_cnt;
  logic [7:0]          shift_in;
  logic                char_done;
  logic [8:0]          rx_char;
  logic                hit;
  logic                store;
  logic                ovf_ev;
  logic                tx_load;
  logic [3:0]          last_bit;
  logic [3:0]          idx;

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign acc   = wb_cyc_i && wb_stb_i && wb_ack_o;
  assign wr    = acc && wb_we_i;
  assign rd    = req && !wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat  = wb_dat_i & wmask;

  // Ack one cycle after the request; unmapped offsets still answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (reg_is(wb_adr_i, OFS_CTRL)) begin
      rdata[CTRL_W-1:0] = ctrl_bus;
    end else if (reg_is(wb_adr_i, OFS_IRQ_STAT)) begin
      rdata[IRQ_W-1:0] = irq_stat;
    end else if (reg_is(wb_adr_i, OFS_IRQ_MASK)) begin
      rdata[IRQ_W-1:0] = irq_mask;
    end else if (reg_is(wb_adr_i, OFS_FLAGS)) begin
      rdata[FLAG_TXE] = !tx_full;
      rdata[FLAG_RXC] = rx_full;
    end else if (reg_is(wb_adr_i, OFS_STATUS)) begin
      rdata[STAT_SYNC] = sync_pending;
      rdata[STAT_OVF]  = rx_overflow_flag;
    end else if (reg_is(wb_adr_i, OFS_MATCH)) begin
      rdata[MATCH_ADDR_LO +: 8] = match_bus[7:0];
      rdata[MATCH_MASK_LO +: 8] = match_bus[15:8];
    end else if (reg_is(wb_adr_i, OFS_DATA)) begin
      rdata[8:0] = rx_overflow_flag ? 9'h000 : rx_head;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rdata;
    end
  end

  // Bus-side copies of control and address; the core copies follow after the crossing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_bus  <= CTRL_RST;
      match_bus <= 16'(MATCH_RST);
    end else if (wr && reg_is(wb_adr_i, OFS_CTRL)) begin
      ctrl_bus <= (ctrl_bus & ~wmask[CTRL_W-1:0]) | wdat[CTRL_W-1:0];
    end else if (wr && reg_is(wb_adr_i, OFS_MATCH)) begin
      match_bus <= (match_bus & ~{wmask[23:16], wmask[7:0]}) | {wdat[23:16], wdat[7:0]};
    end
  end

  // A new write restarts the crossing, so the core never sees a half update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_cnt <= 3'h0;
    end else if (wr && (reg_is(wb_adr_i, OFS_CTRL) || reg_is(wb_adr_i, OFS_MATCH))) begin
      sync_cnt <= SYNC_LOAD;
    end else if (sync_cnt != 3'h0) begin
      sync_cnt <= sync_cnt - 3'h1;
    end
  end
  assign sync_pending = sync_cnt != 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_core  <= CTRL_RST;
      match_core <= 16'(MATCH_RST);
    end else if (sync_cnt == 3'h1) begin
      ctrl_core  <= ctrl_bus;
      match_core <= match_bus;
    end
  end

  // Link inputs: first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_m  <= 1'b0;
      sck_s  <= 1'b0;
      sck_d  <= 1'b0;
      ss_m   <= 1'b1;
      ss_s   <= 1'b1;
      ss_d   <= 1'b1;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      sck_m  <= sck_i;
      sck_s  <= sck_m;
      sck_d  <= sck_s;
      ss_m   <= ss_n_i;
      ss_s   <= ss_m;
      ss_d   <= ss_s;
      mosi_m <= mosi_i;
      mosi_s <= mosi_m;
    end
  end
  assign rise     = sck_s && !sck_d && !ss_s;
  assign fall     = !sck_s && sck_d && !ss_s;
  assign frame_go = !ss_s && ss_d;
  assign last_bit = ctrl_core[CTRL_CHAR9] ? 4'h8 : 4'h7;
  assign idx      = last_bit - bit_cnt;

  always_comb begin
    char_done  = rise && (state != ST_IDLE) && (bit_cnt == last_bit);
    rx_char    = ctrl_core[CTRL_CHAR9] ? {shift_in, mosi_s} : {1'b0, shift_in[6:0], mosi_s};
    hit        = addr_hit(ctrl_core[CTRL_MODE +: 2], rx_char[7:0],
                          match_core[7:0], match_core[15:8]);
    store      = char_done && ctrl_core[CTRL_RXEN] &&
                 ((state == ST_DATA) || ((state == ST_ADDR) && hit));
    ovf_ev     = store && rx_full && !(rd && reg_is(wb_adr_i, OFS_DATA));
    tx_load    = frame_go || char_done;
    next_state = state;
    if (ss_s) begin
      next_state = ST_IDLE;
    end else if (frame_go) begin
      next_state = ctrl_core[CTRL_FRAME_FORMAT_SELECT] ? ST_ADDR : ST_DATA;
    end else if (char_done && (state == ST_ADDR)) begin
      next_state = hit ? ST_DATA : ST_SKIP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= next_state;
        ST_ADDR: state <= next_state;
        ST_DATA: state <= next_state;
        ST_SKIP: state <= next_state;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_cnt  <= 4'h0;
      shift_in <= 8'h00;
    end else if (frame_go || char_done) begin
      bit_cnt  <= 4'h0;
      shift_in <= 8'h00;
    end else if (rise && (state != ST_IDLE)) begin
      bit_cnt  <= bit_cnt + 4'h1;
      shift_in <= {shift_in[6:0], mosi_s};
    end
  end

  // Receive buffer; an overflow zeroes the head so the flag speaks for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_head <= DATA_RST;
      rx_full <= 1'b0;
    end else if (!ctrl_core[CTRL_RXEN]) begin
      rx_full <= 1'b0;
    end else if (ovf_ev) begin
      rx_head <= 9'h000;
    end else if (store) begin
      rx_head <= rx_char;
      rx_full <= 1'b1;
    end else if (rd && reg_is(wb_adr_i, OFS_DATA)) begin
      rx_full <= 1'b0;
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_overflow_flag <= 1'b0;
    end else if (ovf_ev) begin
      rx_overflow_flag <= 1'b1;
    end else if (!ctrl_core[CTRL_RXEN]) begin
      rx_overflow_flag <= 1'b0;
    end else if (wr && reg_is(wb_adr_i, OFS_STATUS) && wdat[STAT_OVF]) begin
      rx_overflow_flag <= 1'b0;
    end
  end

  // Transmit buffer; a write in the load cycle is kept for the next character
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf  <= DATA_RST;
      tx_full <= 1'b0;
      tx_char <= DATA_RST;
    end else begin
      if (tx_load) begin
        tx_char <= tx_full ? tx_buf : 9'h000;
      end
      if (wr && reg_is(wb_adr_i, OFS_DATA)) begin
        tx_buf  <= (tx_buf & ~wmask[8:0]) | wdat[8:0];
        tx_full <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
    end
  end

  // Mode 0: data changes on the falling edge, first bit set at select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miso_o      <= 1'b0;
      miso_oe_n_o <= 1'b1;
    end else begin
      miso_oe_n_o <= ss_s;
      if (frame_go) begin
        miso_o <= tx_full ? tx_buf[last_bit] : 1'b0;
      end else if (fall) begin
        miso_o <= tx_char[idx];
      end
    end
  end

  // Interrupts
  assign irq_ev = {ovf_ev, tx_load && tx_full, store};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq_o    <= 1'b0;
    end else begin
      if (wr && reg_is(wb_adr_i, OFS_IRQ_STAT)) begin
        irq_stat <= (irq_stat & ~wdat[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_stat <= irq_stat | irq_ev;
      end
      if (wr && reg_is(wb_adr_i, OFS_IRQ_MASK)) begin
        irq_mask <= (irq_mask & ~wmask[IRQ_W-1:0]) | wdat[IRQ_W-1:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_sync_hold;
    sync_pending ##1 sync_pending ##1 !sync_pending;
  endsequence

  chk_sync_busy: assert property (
    (wr && reg_is(wb_adr_i, OFS_CTRL)) ##1 !wr |-> s_sync_hold)
    else $error("sync_pending did not cover the crossing");
  chk_sync_done: assert property (
    $fell(sync_pending) |-> (ctrl_core == ctrl_bus && match_core == match_bus))
    else $error("core copy differs after crossing");
  chk_sync_ro: assert property (
    (!sync_pending && !wr) |=> !sync_pending)
    else $error("sync_pending rose without a write");
  chk_ovf_set: assert property (ovf_ev |=> rx_overflow_flag && rx_full)
    else $error("overflow not flagged");
  chk_ovf_keep: assert property (
    (rx_overflow_flag && ctrl_core[CTRL_RXEN] && !(wr && wdat[STAT_OVF])) |=> rx_overflow_flag)
    else $error("overflow flag lost");
  chk_ovf_zero: assert property (
    (req && !wb_we_i && reg_is(wb_adr_i, OFS_DATA) && rx_overflow_flag) |=> wb_dat_o[8:0] == 9'h000)
    else $error("overflowed character not zero");
  chk_rx_read: assert property (
    (req && !wb_we_i && reg_is(wb_adr_i, OFS_DATA) && !rx_overflow_flag)
      |=> wb_dat_o[8:0] == $past(rx_head))
    else $error("data read not buffer head");
  chk_tx_write: assert property (
    (wr && reg_is(wb_adr_i, OFS_DATA) && wb_sel_i[1:0] == 2'h3)
      |=> tx_full && tx_buf == $past(wb_dat_i[8:0]))
    else $error("transmit buffer not loaded");
  chk_rxc_set: assert property (
    (store && ctrl_core[CTRL_RXEN]) |=> ##[0:1] rx_full)
    else $error("rx complete not set");
  chk_filter_skip: assert property (
    (char_done && state == ST_ADDR && !hit && !ss_s) |=> state == ST_SKIP)
    else $error("unmatched address not skipped");
endmodule : spisad_top
`default_nettype wire

// ---- tb/spisad_spi_master.sv ----
`default_nettype none
module spisad_spi_master (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output var  logic sck_o,
  output var  logic ss_n_o,
  output var  logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_o  = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Mode 0, MSB first, four clocks a half period; sck stands low outside frames
  task automatic shift(input logic [8:0] tx, input int nb, output logic [8:0] rx);
    rx = 9'h000;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi_o <= tx[i];
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rx[i] = miso_i;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
  endtask : shift
  task automatic frame(input logic [7:0] c0, input logic [7:0] c1, input logic two,
                       output logic [7:0] r0);
    logic [8:0] r;
    @(posedge clk_i);
    ss_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    shift({1'b0, c0}, 8, r);
    r0 = r[7:0];
    if (two) shift({1'b0, c1}, 8, r);
    repeat (4) @(posedge clk_i);
    ss_n_o <= 1'b1;
    // Released line flips, so a stale level cannot pass for data
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask : frame
  // Single nine-bit character for the wide mode
  task automatic frame9(input logic [8:0] c0, output logic [8:0] r0);
    @(posedge clk_i);
    ss_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    shift(c0, 9, r0);
    repeat (4) @(posedge clk_i);
    ss_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (8) @(posedge clk_i);
  endtask : frame9
endmodule : spisad_spi_master
`default_nettype wire

// ---- tb/spisad_tb_top.sv ----
`default_nettype none
module spisad_tb_top;
  import spisad_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'hF;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        ack;
  logic        sck;
  logic        ss_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe_n;
  logic        irq;
  logic [7:0]  rx;
  logic [8:0]  rx9;
  int          err_total = 0;
  int          checked   = 0;
  // Control, match word, address char, expected flags
  localparam logic [55:0] AM_TAB [8] = '{
    {8'h03, 32'h000F_0050, 8'h5A, 8'h03}, {8'h03, 32'h000F_0050, 8'h6A, 8'h01},
    {8'h07, 32'h0021_0050, 8'h21, 8'h03}, {8'h07, 32'h0021_0050, 8'h22, 8'h01},
    {8'h0B, 32'h0010_0030, 8'h30, 8'h03}, {8'h0B, 32'h0010_0030, 8'h31, 8'h01},
    {8'h0B, 32'h0010_0030, 8'h10, 8'h03}, {8'h0B, 32'h0010_0030, 8'h0F, 8'h01}};

  always #25 clk_i = ~clk_i;

  spisad_top u_spisad_top (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wb_cyc_i    (cyc),
    .wb_stb_i    (stb),
    .wb_we_i     (we),
    .wb_adr_i    (adr),
    .wb_sel_i    (sel),
    .wb_dat_i    (wdat),
    .wb_dat_o    (rdat),
    .wb_ack_o    (ack),
    .sck_i       (sck),
    .ss_n_i      (ss_n),
    .mosi_i      (mosi),
    .miso_o      (miso),
    .miso_oe_n_o (miso_oe_n),
    .irq_o       (irq)
  );

  spisad_spi_master u_spisad_spi_master (
    .clk_i  (clk_i),
    .miso_i (miso),
    .sck_o  (sck),
    .ss_n_o (ss_n),
    .mosi_o (mosi)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask : rd

  task automatic wrap_up();
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(OFS_MATCH, MATCH_RST);
    rd(OFS_DATA, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0001);
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0000_0000);
    wr(OFS_MATCH, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0000_8000);
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_MATCH, 32'h00FF_00FF);
    sel <= 4'h4;
    wr(OFS_MATCH, 32'h0000_0000);
    sel <= 4'hF;
    rd(OFS_MATCH, 32'h0000_00FF);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    fork
      u_spisad_spi_master.frame(8'hA5, 8'h00, 1'b0, rx);
      begin
        repeat (10) @(posedge clk_i);
        chk(32'(miso_oe_n), 32'h0000_0000);
      end
    join
    chk(32'(miso_oe_n), 32'h0000_0001);
    rd(OFS_FLAGS, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    rd(OFS_DATA, 32'h0000_00A5);
    rd(OFS_FLAGS, 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    rd(OFS_IRQ_STAT, 32'h0000_0000);
    // Second char arrives while the first is unread
    u_spisad_spi_master.frame(8'h11, 8'h22, 1'b1, rx);
    rd(OFS_STATUS, 32'h0000_0004);
    wr(OFS_IRQ_MASK, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_STATUS, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0004);
    rd(OFS_DATA, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0004);
    rd(OFS_STATUS, 32'h0000_0000);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0000_0000);
    u_spisad_spi_master.frame(8'h33, 8'h44, 1'b1, rx);
    wr(OFS_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk_i);
    rd(OFS_STATUS, 32'h0000_0000);
    rd(OFS_FLAGS, 32'h0000_0001);
    wr(OFS_DATA, 32'h0000_003C);
    rd(OFS_FLAGS, 32'h0000_0000);
    u_spisad_spi_master.frame(8'h00, 8'h00, 1'b0, rx);
    chk(32'(rx), 32'h0000_003C);
    rd(OFS_IRQ_STAT, 32'h0000_0007);
    rd(OFS_FLAGS, 32'h0000_0001);
    foreach (AM_TAB[i]) begin
      wr(OFS_CTRL, 32'(AM_TAB[i][55:48]));
      wr(OFS_MATCH, AM_TAB[i][47:16]);
      u_spisad_spi_master.frame(AM_TAB[i][15:8], 8'h00, 1'b0, rx);
      rd(OFS_FLAGS, 32'(AM_TAB[i][7:0]));
      if (AM_TAB[i][1]) rd(OFS_DATA, 32'(AM_TAB[i][15:8]));
    end
    // Nine-bit characters both ways
    wr(OFS_CTRL, 32'h0000_0011);
    wr(OFS_DATA, 32'h0000_0155);
    u_spisad_spi_master.frame9(9'h1A3, rx9);
    chk(32'(rx9), 32'h0000_0155);
    rd(OFS_DATA, 32'h0000_01A3);
    wrap_up();
  end
endmodule : spisad_tb_top
`default_nettype wire
